// >>> include/mis_pkg.sv
// mis_pkg: shared constants and types of the interrupt sequencer
package mis_pkg;
   // vector table, high byte address of each two-byte vector
   localparam logic [13:0] VEC_ASYNC = 14'h3ff0;
   localparam logic [13:0] VEC_SYNC  = 14'h3ff2;
   localparam logic [13:0] VEC_T2    = 14'h3ff4;
   localparam logic [13:0] VEC_T1    = 14'h3ff6;
   localparam logic [13:0] VEC_CORE  = 14'h3ff8;
   localparam logic [13:0] VEC_EXT   = 14'h3ffa;
   localparam logic [13:0] VEC_TRAP  = 14'h3ffc;
   localparam logic [13:0] VEC_RESET = 14'h3ffe;

   // request kinds; hardware kinds are ordered, 0 highest
   localparam logic [2:0] K_EXT   = 3'h0;
   localparam logic [2:0] K_CORE  = 3'h1;
   localparam logic [2:0] K_T1    = 3'h2;
   localparam logic [2:0] K_T2    = 3'h3;
   localparam logic [2:0] K_SYNC  = 3'h4;
   localparam logic [2:0] K_ASYNC = 3'h5;
   localparam logic [2:0] K_TRAP  = 3'h6;
   localparam logic [2:0] K_RESET = 3'h7;
   localparam int         NUM_HW  = 6;

   // bytes pushed per entry: pc low, pc high, index, accumulator, flags
   localparam logic [2:0] STACK_BYTES = 3'h5;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_ENABLE = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_VECTOR = 8'h0c;

   // control register fields
   localparam int CTRL_MASK_BIT = 0;
   localparam int CTRL_EDGE_BIT = 1;
   localparam int CTRL_KEY_LSB  = 8;

   // enable register fields
   localparam int EN_CORE_WRAP = 0;
   localparam int EN_PERIODIC  = 1;
   localparam int EN_T1_CAP    = 2;
   localparam int EN_T1_CMP    = 3;
   localparam int EN_T1_WRAP   = 4;
   localparam int EN_T2_CAP    = 5;
   localparam int EN_T2_CMP    = 6;
   localparam int EN_T2_WRAP   = 7;
   localparam int EN_SYNC      = 8;
   localparam int EN_TX        = 9;
   localparam int EN_RX        = 10;
   localparam int EN_IDLE      = 11;
   localparam int EN_W         = 12;

   // status register fields
   localparam int STS_REQ_LSB   = 0;
   localparam int STS_LATCH_BIT = 8;
   localparam int STS_PIN_BIT   = 9;
   localparam int STS_TRAP_BIT  = 10;
   localparam int STS_BUSY_BIT  = 11;
   localparam int STS_KIND_LSB  = 16;

   // values after reset
   localparam logic       MASK_RST = 1'b1;
   localparam logic       EDGE_RST = 1'b0;
   localparam logic [11:0] EN_RST  = 12'h000;

   typedef enum logic [2:0] {
      S_RUN, S_STACK, S_MASK, S_PRIO, S_VEC_HI, S_VEC_LO, S_JUMP, S_RESET
   } mis_state_type;
endpackage : mis_pkg

// >>> hw/mis_pin_sync.sv
// mis_pin_sync: three-stage synchroniser for asynchronous pins
`timescale 1ns/1ps
module mis_pin_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // asynchronous pins, idle high
   input  wire logic [W-1:0] pin_i,
   // second and third stage
   output logic      [W-1:0] mid_o,
   output logic      [W-1:0] late_o
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
   } mis_sync_type;

   mis_sync_type q;
   mis_sync_type next_q;

   always_comb begin
      next_q.s1 = pin_i;
      next_q.s2 = q.s1;
      next_q.s3 = q.s2;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '1;
      end else begin
         q <= next_q;
      end
   end

   assign mid_o  = q.s2;
   assign late_o = q.s3;
endmodule : mis_pin_sync

// >>> hw/mis_sequencer.sv
// mis_sequencer: interrupt recognition, priority and vector sequencing
`timescale 1ns/1ps
module mis_sequencer
   import mis_pkg::*;
#(
   parameter int KEY_W = 8
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // wishbone slave
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [7:0]       wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   output logic      [31:0]      wb_dat_o,
   output logic                  wb_ack_o,
   // pins, asynchronous, active low
   input  wire logic             irq_pin_n_i,
   input  wire logic [KEY_W-1:0] key_pin_n_i,
   input  wire logic             reset_pin_n_i,
   // internal reset sources
   input  wire logic             internal_reset_i,
   // core tick timer flags
   input  wire logic             counter_wrap_flag_i,
   input  wire logic             periodic_tick_flag_i,
   // wide timer flags
   input  wire logic             t1_capture_flag_i,
   input  wire logic             t1_compare_flag_i,
   input  wire logic             t1_counter_wrap_flag_i,
   input  wire logic             t2_capture_flag_i,
   input  wire logic             t2_compare_flag_i,
   input  wire logic             t2_counter_wrap_flag_i,
   // serial unit flags
   input  wire logic             sync_xfer_done_flag_i,
   input  wire logic             sync_mode_fault_flag_i,
   input  wire logic             tx_buffer_empty_flag_i,
   input  wire logic             tx_complete_flag_i,
   input  wire logic             rx_buffer_full_flag_i,
   input  wire logic             rx_overrun_flag_i,
   input  wire logic             line_idle_flag_i,
   // cpu handshake
   input  wire logic             instr_done_i,
   input  wire logic             soft_trap_fetch_i,
   input  wire logic             return_from_trap_instr_i,
   input  wire logic             restored_mask_i,
   // cpu control
   output logic                  global_mask_o,
   output logic                  stack_req_o,
   output logic      [2:0]       stack_index_o,
   output logic                  vector_read_o,
   output logic      [13:0]      vector_addr_o,
   output logic                  service_start_o,
   output logic                  halt_o,
   output logic                  branch_if_pin_high_o,
   output logic                  branch_if_pin_low_o
);
   typedef struct packed {
      mis_state_type    st;
      logic             mask;
      logic             edge_only;
      logic [KEY_W-1:0] key_en;
      logic [EN_W-1:0]  en;
      logic             rst_lvl;
      logic             ext_lvl;
      logic [KEY_W-1:0] key_lvl;
      logic             pin_low;
      logic             ext_latch;
      logic             trap_pend;
      logic             trap_hw_first;
      logic [2:0]       kind;
      logic [2:0]       cnt;
      logic [13:0]      vec;
      logic             vec_rd;
      logic             stack_req;
      logic             svc_start;
      logic             halt;
      logic             ack;
      logic [31:0]      dat;
   } mis_regs_type;

   localparam mis_regs_type RST_Q = '{
      st: S_RESET, mask: MASK_RST, edge_only: EDGE_RST, key_en: '0, en: EN_RST,
      rst_lvl: 1'b1, ext_lvl: 1'b1, key_lvl: '1, pin_low: 1'b0, ext_latch: 1'b0,
      trap_pend: 1'b0, trap_hw_first: 1'b0, kind: K_RESET, cnt: 3'h0,
      vec: 14'h0000, vec_rd: 1'b0, stack_req: 1'b0, svc_start: 1'b0,
      halt: 1'b1, ack: 1'b0, dat: 32'h0000_0000};

   mis_regs_type q;
   mis_regs_type next_q;

   // highest hardware priority is the lowest index
   function automatic logic [2:0] pick_src(input logic [NUM_HW-1:0] r);
      logic [2:0] k;
      k = K_ASYNC;
      for (int i = NUM_HW - 1; i >= 0; i--) begin
         if (r[i]) begin
            k = 3'(i);
         end
      end
      return k;
   endfunction : pick_src

   function automatic logic [13:0] vec_of(input logic [2:0] k);
      case (k)
         K_EXT:   return VEC_EXT;
         K_CORE:  return VEC_CORE;
         K_T1:    return VEC_T1;
         K_T2:    return VEC_T2;
         K_SYNC:  return VEC_SYNC;
         K_ASYNC: return VEC_ASYNC;
         K_TRAP:  return VEC_TRAP;
         default: return VEC_RESET;
      endcase
   endfunction : vec_of

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
      logic [31:0] m;
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      return (n & m) | (o & ~m);
   endfunction : merge

   // pin synchronisation; a level is accepted once stages two and three agree
   logic [KEY_W+1:0] s_mid;
   logic [KEY_W+1:0] s_late;
   logic [KEY_W+1:0] lvl_q;
   logic [KEY_W+1:0] lvl_d;

   mis_pin_sync #(
      .W (KEY_W + 2)
   ) u_sync (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .pin_i  ({reset_pin_n_i, irq_pin_n_i, key_pin_n_i}),
      .mid_o  (s_mid),
      .late_o (s_late)
   );

   assign lvl_q = {q.rst_lvl, q.ext_lvl, q.key_lvl};
   assign lvl_d = ((s_mid ~^ s_late) & s_late) | ((s_mid ^ s_late) & lvl_q);

   logic              ext_fall;
   logic              key_fall;
   logic              key_low;
   logic              reset_req;
   logic [NUM_HW-1:0] hw_req;
   logic              hw_ok;

   assign ext_fall  = q.ext_lvl & ~lvl_d[KEY_W];
   assign key_fall  = |(q.key_lvl & ~lvl_d[KEY_W-1:0] & q.key_en);
   assign key_low   = |(~q.key_lvl & q.key_en);
   assign reset_req = ~q.rst_lvl | internal_reset_i;

   // edge-only mode serves the latch alone; otherwise a held low level also asks
   assign hw_req[K_EXT] = q.ext_latch | (~q.edge_only & (~q.ext_lvl | key_low));
   assign hw_req[K_CORE] = (counter_wrap_flag_i & q.en[EN_CORE_WRAP])
                         | (periodic_tick_flag_i & q.en[EN_PERIODIC]);
   assign hw_req[K_T1] = (t1_capture_flag_i & q.en[EN_T1_CAP])
                       | (t1_compare_flag_i & q.en[EN_T1_CMP])
                       | (t1_counter_wrap_flag_i & q.en[EN_T1_WRAP]);
   assign hw_req[K_T2] = (t2_capture_flag_i & q.en[EN_T2_CAP])
                       | (t2_compare_flag_i & q.en[EN_T2_CMP])
                       | (t2_counter_wrap_flag_i & q.en[EN_T2_WRAP]);
   assign hw_req[K_SYNC] = (sync_xfer_done_flag_i | sync_mode_fault_flag_i)
                         & q.en[EN_SYNC];
   assign hw_req[K_ASYNC] = ((tx_buffer_empty_flag_i | tx_complete_flag_i) & q.en[EN_TX])
                          | ((rx_buffer_full_flag_i | rx_overrun_flag_i) & q.en[EN_RX])
                          | (line_idle_flag_i & q.en[EN_IDLE]);
   assign hw_ok = (|hw_req) & ~q.mask;

   // register bus
   logic        bus_req;
   logic        bus_wr;
   logic [31:0] ctrl_rd;
   logic [31:0] en_rd;
   logic [31:0] sts_rd;
   logic [31:0] vec_rd;
   logic [31:0] rd_data;
   logic [31:0] ctrl_new;
   logic [31:0] en_new;

   assign bus_req = wb_cyc_i & wb_stb_i & ~q.ack;
   assign bus_wr  = bus_req & wb_we_i;
   assign ctrl_rd = {{(24 - KEY_W){1'b0}}, q.key_en, 6'h00, q.edge_only, q.mask};
   assign en_rd   = {{(32 - EN_W){1'b0}}, q.en};
   assign sts_rd  = {13'h0000, q.kind, 4'h0, q.st != S_RUN, q.trap_pend, q.ext_lvl,
                     q.ext_latch, 2'h0, hw_req};
   assign vec_rd  = {18'h00000, q.vec};
   assign ctrl_new = merge(ctrl_rd, wb_dat_i, wb_sel_i);
   assign en_new   = merge(en_rd, wb_dat_i, wb_sel_i);

   always_comb begin
      case (wb_adr_i)
         OFS_CTRL:   rd_data = ctrl_rd;
         OFS_ENABLE: rd_data = en_rd;
         OFS_STATUS: rd_data = sts_rd;
         OFS_VECTOR: rd_data = vec_rd;
         default:    rd_data = 32'h0000_0000;
      endcase
   end

   always_comb begin
      next_q           = q;
      next_q.ack       = bus_req;
      next_q.dat       = bus_req ? rd_data : 32'h0000_0000;
      next_q.vec_rd    = 1'b0;
      next_q.svc_start = 1'b0;
      {next_q.rst_lvl, next_q.ext_lvl, next_q.key_lvl} = lvl_d;
      next_q.pin_low   = ~lvl_d[KEY_W];

      if (bus_wr && wb_adr_i == OFS_CTRL) begin
         next_q.mask      = ctrl_new[CTRL_MASK_BIT];
         next_q.edge_only = ctrl_new[CTRL_EDGE_BIT];
         next_q.key_en    = ctrl_new[CTRL_KEY_LSB +: KEY_W];
      end
      if (bus_wr && wb_adr_i == OFS_ENABLE) begin
         next_q.en = en_new[EN_W-1:0];
      end
      if (return_from_trap_instr_i) begin
         next_q.mask = restored_mask_i;
      end
      // remember whether hardware was already waiting when the trap was fetched
      if (soft_trap_fetch_i) begin
         next_q.trap_pend     = 1'b1;
         next_q.trap_hw_first = hw_ok;
      end

      case (q.st)
         S_RUN: begin
            // only an instruction boundary may start an entry
            if (instr_done_i) begin
               if (q.trap_pend && !(q.trap_hw_first && hw_ok)) begin
                  next_q.kind          = K_TRAP;
                  next_q.trap_pend     = 1'b0;
                  next_q.trap_hw_first = 1'b0;
                  next_q.st            = S_STACK;
                  next_q.cnt           = 3'h0;
                  next_q.stack_req     = 1'b1;
               end else if (hw_ok) begin
                  next_q.kind          = pick_src(hw_req);
                  next_q.trap_hw_first = 1'b0;
                  next_q.st           = S_STACK;
                  next_q.cnt          = 3'h0;
                  next_q.stack_req    = 1'b1;
               end
            end
         end
         S_STACK: begin
            if (q.cnt == STACK_BYTES - 3'h1) begin
               next_q.stack_req = 1'b0;
               next_q.st        = S_MASK;
            end else begin
               next_q.cnt = q.cnt + 3'h1;
            end
         end
         S_MASK: begin
            next_q.mask = 1'b1;
            next_q.st   = S_PRIO;
         end
         S_PRIO: begin
            // if every request vanished during stacking, the accepted one is kept
            if (q.kind != K_TRAP && (|hw_req)) begin
               next_q.kind = pick_src(hw_req);
            end
            if (next_q.kind == K_EXT) begin
               next_q.ext_latch = 1'b0;
            end
            next_q.vec    = vec_of(next_q.kind);
            next_q.vec_rd = 1'b1;
            next_q.st     = S_VEC_HI;
         end
         S_VEC_HI: begin
            next_q.vec    = q.vec + 14'h0001;
            next_q.vec_rd = 1'b1;
            next_q.st     = S_VEC_LO;
         end
         S_VEC_LO: begin
            next_q.svc_start = 1'b1;
            next_q.st        = S_JUMP;
         end
         S_JUMP: begin
            next_q.st = S_RUN;
         end
         S_RESET: begin
            if (!reset_req) begin
               next_q.halt   = 1'b0;
               // a bus write in the release cycle must not leave the mask clear
               next_q.mask   = 1'b1;
               next_q.kind   = K_RESET;
               next_q.vec    = VEC_RESET;
               next_q.vec_rd = 1'b1;
               next_q.st     = S_VEC_HI;
            end
         end
         default: begin
            next_q.st = S_RESET;
         end
      endcase

      // a new edge wins over the clear in the same cycle
      if (ext_fall || key_fall) begin
         next_q.ext_latch = 1'b1;
      end

      // reset alone may cut an instruction short
      if (reset_req) begin
         next_q.st           = S_RESET;
         next_q.halt         = 1'b1;
         next_q.mask         = 1'b1;
         next_q.stack_req    = 1'b0;
         next_q.vec_rd       = 1'b0;
         next_q.svc_start     = 1'b0;
         next_q.trap_pend     = 1'b0;
         next_q.trap_hw_first = 1'b0;
         next_q.ext_latch     = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= RST_Q;
      end else begin
         q <= next_q;
      end
   end

   assign wb_dat_o             = q.dat;
   assign wb_ack_o             = q.ack;
   assign global_mask_o        = q.mask;
   assign stack_req_o          = q.stack_req;
   assign stack_index_o        = q.cnt;
   assign vector_read_o        = q.vec_rd;
   assign vector_addr_o        = q.vec;
   assign service_start_o      = q.svc_start;
   assign halt_o               = q.halt;
   assign branch_if_pin_high_o = q.ext_lvl;
   assign branch_if_pin_low_o  = q.pin_low;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_no_abort: assert property (
      (q.st == S_RUN && !instr_done_i && !reset_req) |=> q.st inside {S_RUN, S_RESET})
      else $error("entry started between instruction boundaries");

   a_masked_stay: assert property (
      (q.st == S_RUN && q.mask && !q.trap_pend && !reset_req) |=> !q.stack_req)
      else $error("masked request started stacking");

   a_stack_then_mask: assert property (
      (q.st == S_STACK && q.cnt == 3'h0 && !reset_req)
      |-> (q.stack_req [*5] ##1 (q.st == S_MASK && !q.stack_req)) or ##[1:6] reset_req)
      else $error("stacking did not take five cycles before masking");

   a_prio_order: assert property (
      (q.st == S_PRIO && q.kind != K_TRAP && (|hw_req) && !reset_req)
      |=> q.kind == pick_src($past(hw_req)))
      else $error("pending request not served in priority order");

   a_trap_unmasked: assert property (
      (q.st == S_RUN && instr_done_i && q.trap_pend && !q.trap_hw_first && !reset_req)
      |=> (q.st == S_STACK && q.kind == K_TRAP))
      else $error("soft trap not taken at its boundary");

   a_reset_vector: assert property (
      (q.st == S_RESET && !reset_req) |=> (q.vec == VEC_RESET && q.vec_rd && q.mask))
      else $error("reset did not fetch the reset vector with mask set");

   a_latency: assert property (
      (q.st == S_RUN && next_q.st == S_STACK)
      |-> ##10 (q.svc_start || $past(reset_req, 1)) or ##[1:10] reset_req)
      else $error("service did not start ten cycles after acceptance");

   a_vector_pair: assert property (
      (q.st == S_VEC_HI && !reset_req) |=> (q.vec_rd && q.vec == $past(q.vec) + 14'h0001))
      else $error("second vector byte not read at the next address");

   a_edge_latch: assert property (
      (ext_fall && !reset_req) |=> q.ext_latch)
      else $error("falling pin edge was not latched");

   a_return_mask: assert property (
      (return_from_trap_instr_i && q.st == S_RUN && !instr_done_i && !reset_req && !bus_wr)
      |=> q.mask == $past(restored_mask_i))
      else $error("return did not restore the stacked mask");
endmodule : mis_sequencer

// >>> sim/mis_cpu_model.sv
// mis_cpu_model: cpu core stand-in giving instruction boundaries and trap fetches
`timescale 1ns/1ps
module mis_cpu_model #(
   parameter int INSTR_LEN = 4
) (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // from the sequencer and the bench
   input  wire logic halt_i,
   input  wire logic trap_req_i,
   // to the sequencer
   output logic      instr_done_o,
   output logic      soft_trap_fetch_o
);
   logic [3:0] cnt;
   logic       want;
   logic       last;
   assign last = (cnt == 4'(INSTR_LEN - 1));
   always_ff @(posedge clk_i) begin
      if (rst_i || halt_i) begin
         cnt <= 4'h0;
         want <= 1'b0;
         instr_done_o <= 1'b0;
         soft_trap_fetch_o <= 1'b0;
      end else begin
         cnt <= last ? 4'h0 : cnt + 4'h1;
         // boundary only once the whole instruction has run
         instr_done_o <= last;
         // fetch is seen at the start, its boundary at the end
         soft_trap_fetch_o <= want && (cnt == 4'h0);
         want <= trap_req_i || (want && (cnt != 4'h0));
      end
   end
endmodule : mis_cpu_model

// >>> sim/testbench.sv
// testbench: directed checks of the interrupt sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
   $display("ERROR %0t got %h want %h", $time, a, b); end end
module testbench
   import mis_pkg::*;
;
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic        ret = 1'b0, ireset = 1'b0, treq = 1'b0, pin_n = 1'b1, rmask = 1'b0;
   logic        ack, done, tfetch, gmask, sreq, vrd, sstart, halt, bph, bpl;
   logic [7:0]  adr = 8'h00, key_n = 8'hff;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic [14:0] fl = 15'h0;
   logic [2:0]  sidx;
   logic [13:0] vaddr;
   int          miscompares = 0, tests_run = 0, hits, stk;
   logic [13:0] exp_vec [15] = '{VEC_CORE, VEC_CORE, VEC_T1, VEC_T1, VEC_T1, VEC_T2, VEC_T2,
      VEC_T2, VEC_SYNC, VEC_SYNC, VEC_ASYNC, VEC_ASYNC, VEC_ASYNC, VEC_ASYNC, VEC_ASYNC};
   always #12.5 clk_i = ~clk_i;
   mis_sequencer u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .irq_pin_n_i(pin_n), .key_pin_n_i(key_n), .reset_pin_n_i(1'b1),
      .internal_reset_i(ireset), .counter_wrap_flag_i(fl[0]), .periodic_tick_flag_i(fl[1]),
      .t1_capture_flag_i(fl[2]), .t1_compare_flag_i(fl[3]), .t1_counter_wrap_flag_i(fl[4]),
      .t2_capture_flag_i(fl[5]), .t2_compare_flag_i(fl[6]), .t2_counter_wrap_flag_i(fl[7]),
      .sync_xfer_done_flag_i(fl[8]), .sync_mode_fault_flag_i(fl[9]),
      .tx_buffer_empty_flag_i(fl[10]), .tx_complete_flag_i(fl[11]),
      .rx_buffer_full_flag_i(fl[12]), .rx_overrun_flag_i(fl[13]), .line_idle_flag_i(fl[14]),
      .instr_done_i(done), .soft_trap_fetch_i(tfetch), .return_from_trap_instr_i(ret),
      .restored_mask_i(rmask), .global_mask_o(gmask), .stack_req_o(sreq),
      .stack_index_o(sidx), .vector_read_o(vrd), .vector_addr_o(vaddr),
      .service_start_o(sstart), .halt_o(halt), .branch_if_pin_high_o(bph),
      .branch_if_pin_low_o(bpl));
   mis_cpu_model u_cpu (.clk_i(clk_i), .rst_i(rst_i), .halt_i(halt), .trap_req_i(treq),
      .instr_done_o(done), .soft_trap_fetch_o(tfetch));
   task automatic final_report;
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : final_report
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk_i);
      while (ack !== 1'b1) @(posedge clk_i);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : bus
   // stacking bytes in index order, vector pair, then the jump with the mask already set
   task automatic serve(input logic [13:0] v);
      stk = 0;
      while (vrd !== 1'b1) begin
         if (sreq === 1'b1) begin
            `CHK(sidx, 3'(stk))
            stk++;
         end
         @(posedge clk_i);
      end
      `CHK(stk, (v == VEC_RESET) ? 0 : int'(STACK_BYTES))
      `CHK(vaddr, v)
      @(posedge clk_i);
      `CHK(vaddr, v + 14'h1)
      @(posedge clk_i);
      `CHK(sstart, 1'b1)
      `CHK(gmask, 1'b1)
   endtask : serve
   // waits out the pin synchroniser so a released pin is not seen as a level request
   task automatic unmask;
      repeat (6) @(posedge clk_i);
      ret <= 1'b1;
      @(posedge clk_i);
      ret <= 1'b0;
      @(posedge clk_i);
      `CHK(gmask, 1'b0)
   endtask : unmask
   task automatic quiet;
      hits = 0;
      repeat (40) begin
         @(posedge clk_i);
         if (vrd === 1'b1) hits++;
      end
   endtask : quiet
   initial begin
      #500000;
      miscompares++;
      final_report();
   end
   initial begin
      repeat (2) @(posedge clk_i);
      `CHK(halt, 1'b1)
      rst_i <= 1'b0;
      serve(VEC_RESET);
      bus(1'b0, OFS_CTRL, 32'h0);
      `CHK(q, 32'h00000001)
      bus(1'b0, 8'h10, 32'h0);
      `CHK(q, 32'h0)
      bus(1'b1, OFS_ENABLE, 32'h00000fff);
      fl <= 15'h0001;
      quiet();
      `CHK(hits, 0)
      bus(1'b1, OFS_ENABLE, 32'h00000000);
      bus(1'b1, OFS_CTRL, 32'h0000ff00);
      quiet();
      `CHK(hits, 0)
      fl <= 15'h0;
      bus(1'b1, OFS_ENABLE, 32'h00000fff);
      $display("reset and gating done");
      for (int i = 0; i < 15; i++) begin
         fl <= 15'h1 << i;
         serve(exp_vec[i]);
         fl <= 15'h0;
         unmask();
      end
      $display("source table done");
      fl <= 15'h4081;
      serve(VEC_CORE);
      fl <= 15'h4080;
      treq <= 1'b1;
      @(posedge clk_i);
      treq <= 1'b0;
      serve(VEC_TRAP);
      unmask();
      serve(VEC_T2);
      fl <= 15'h0;
      unmask();
      fl <= 15'h0001;
      treq <= 1'b1;
      @(posedge clk_i);
      treq <= 1'b0;
      serve(VEC_CORE);
      fl <= 15'h0;
      serve(VEC_TRAP);
      unmask();
      $display("priority and trap done");
      pin_n <= 1'b0;
      serve(VEC_EXT);
      `CHK(bpl, 1'b1)
      pin_n <= 1'b1;
      unmask();
      key_n <= 8'hfe;
      serve(VEC_EXT);
      `CHK(bph, 1'b1)
      key_n <= 8'hff;
      unmask();
      bus(1'b1, OFS_CTRL, 32'h0000ff02);
      pin_n <= 1'b0;
      serve(VEC_EXT);
      pin_n <= 1'b1;
      repeat (6) @(posedge clk_i);
      pin_n <= 1'b0;
      unmask();
      serve(VEC_EXT);
      unmask();
      quiet();
      `CHK(hits, 0)
      rmask <= 1'b1;
      ret <= 1'b1;
      @(posedge clk_i);
      ret <= 1'b0;
      rmask <= 1'b0;
      @(posedge clk_i);
      `CHK(gmask, 1'b1)
      $display("pin tests done");
      ireset <= 1'b1;
      repeat (2) @(posedge clk_i);
      ireset <= 1'b0;
      serve(VEC_RESET);
      $display("internal reset done");
      final_report();
   end
endmodule : testbench
